// ---- msq_defines.vh ----
// constants for the instruction sequencing core: phases, field positions, codes, addresses
// assumes it is included by every design file of the core, once per file
`ifndef MSQ_DEFINES_VH
`define MSQ_DEFINES_VH

// ----------------------------------------------------------------
// instruction cycle
// ----------------------------------------------------------------
`define MSQ_PHASES 4
`define MSQ_PHASE_LAST 2'h3
`define MSQ_PHASE_FIRST 2'h0

// ----------------------------------------------------------------
// instruction word fields (14-bit word)
// ----------------------------------------------------------------
`define MSQ_CLS_HI 13
`define MSQ_CLS_LO 11
`define MSQ_CLS_JUMP 3'h7
`define MSQ_CLS_CALL 3'h6
`define MSQ_CLS_BIT 3'h5
`define MSQ_CLS_IMM 3'h4
`define MSQ_DEST_BIT 12
`define MSQ_FUNC_HI 11
`define MSQ_FUNC_LO 6
`define MSQ_ADDR_HI 5
`define MSQ_ADDR_LO 0
`define MSQ_BSUB_HI 10
`define MSQ_BSUB_LO 9
`define MSQ_BIDX_HI 8
`define MSQ_BIDX_LO 6
`define MSQ_ISUB_HI 10
`define MSQ_ISUB_LO 8
`define MSQ_IMM_HI 7
`define MSQ_IMM_LO 0
`define MSQ_NOP_WORD 14'h0DC0

// bit operation sub-codes
`define MSQ_BSUB_SET 2'h0
`define MSQ_BSUB_CLR 2'h1
`define MSQ_BSUB_SKZ 2'h2
`define MSQ_BSUB_SKNZ 2'h3

// immediate sub-codes
`define MSQ_ISUB_ADD 3'h0
`define MSQ_ISUB_SUB 3'h1
`define MSQ_ISUB_AND 3'h2
`define MSQ_ISUB_OR 3'h3
`define MSQ_ISUB_XOR 3'h4
`define MSQ_ISUB_MOV 3'h5

// memory-operand function codes, group 0 is an alu operation in the low nibble
`define MSQ_FGRP_ALU 2'h0
`define MSQ_FUNC_SZ 6'h10
`define MSQ_FUNC_SIZ 6'h11
`define MSQ_FUNC_SDZ 6'h12
`define MSQ_FUNC_TABRD 6'h13
`define MSQ_FUNC_RET 6'h14
`define MSQ_FUNC_RETURN_FROM_INTERRUPT 6'h15
`define MSQ_FUNC_NOP 6'h17

// ----------------------------------------------------------------
// alu operations
// ----------------------------------------------------------------
`define MSQ_ALU_ADD 4'h0
`define MSQ_ALU_ADC 4'h1
`define MSQ_ALU_SUB 4'h2
`define MSQ_ALU_SBC 4'h3
`define MSQ_ALU_AND 4'h4
`define MSQ_ALU_OR 4'h5
`define MSQ_ALU_XOR 4'h6
`define MSQ_ALU_CPL 4'h7
`define MSQ_ALU_INC 4'h8
`define MSQ_ALU_DEC 4'h9
`define MSQ_ALU_RR 4'hA
`define MSQ_ALU_RL 4'hB
`define MSQ_ALU_RRC 4'hC
`define MSQ_ALU_RLC 4'hD
`define MSQ_ALU_PASSB 4'hE
`define MSQ_ALU_PASSA 4'hF

// ----------------------------------------------------------------
// special data memory addresses and status layout
// ----------------------------------------------------------------
`define MSQ_SFR_PCL 6'h02
`define MSQ_SFR_STATUS 6'h0A
`define MSQ_SFR_TBLP 6'h07
`define MSQ_SFR_TBLH 6'h08
`define MSQ_STAT_C 0
`define MSQ_STAT_AC 1
`define MSQ_STAT_Z 2
`define MSQ_STAT_OV 3

`endif

// ---- msq_alu.v ----
// eight-bit arithmetic and logic unit of the sequencing core, purely combinational
// assumes the caller registers whatever it keeps; carry out of subtract means no borrow
`timescale 1ns/1ps
`include "msq_defines.vh"

module msq_alu #(
  parameter DATA_W = 8
) (
  input wire [3:0] op,
  input wire [DATA_W-1:0] a,
  input wire [DATA_W-1:0] b,
  input wire cin,
  output reg [DATA_W-1:0] res,
  output reg cout,
  output reg acout,
  output reg ovout
);

  reg [DATA_W-1:0] bx;
  reg ci;
  reg [DATA_W:0] sum;
  reg [4:0] nib;

  always @* begin
    // subtract is add of the inverted operand plus one; carry out is then no-borrow
    bx = ((op == `MSQ_ALU_SUB) || (op == `MSQ_ALU_SBC)) ? ~b : b;
    case (op)
      `MSQ_ALU_ADC: ci = cin;
      `MSQ_ALU_SUB: ci = 1'b1;
      `MSQ_ALU_SBC: ci = cin;
      default: ci = 1'b0;
    endcase
    sum = {1'b0, a} + {1'b0, bx} + {{DATA_W{1'b0}}, ci};
    nib = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
    res = sum[DATA_W-1:0];
    cout = cin;
    acout = nib[4];
    ovout = (a[DATA_W-1] == bx[DATA_W-1]) && (sum[DATA_W-1] != a[DATA_W-1]);
    case (op)
      `MSQ_ALU_ADD, `MSQ_ALU_ADC, `MSQ_ALU_SUB, `MSQ_ALU_SBC: begin
        cout = sum[DATA_W];
      end
      `MSQ_ALU_AND: res = a & b;
      `MSQ_ALU_OR: res = a | b;
      `MSQ_ALU_XOR: res = a ^ b;
      `MSQ_ALU_CPL: res = ~b;
      `MSQ_ALU_INC: res = b + {{(DATA_W-1){1'b0}}, 1'b1};
      `MSQ_ALU_DEC: res = b - {{(DATA_W-1){1'b0}}, 1'b1};
      `MSQ_ALU_RR: res = {b[0], b[DATA_W-1:1]};
      `MSQ_ALU_RL: res = {b[DATA_W-2:0], b[DATA_W-1]};
      `MSQ_ALU_RRC: begin
        res = {cin, b[DATA_W-1:1]};
        cout = b[0];
      end
      `MSQ_ALU_RLC: begin
        res = {b[DATA_W-2:0], cin};
        cout = b[DATA_W-1];
      end
      `MSQ_ALU_PASSB: res = b;
      default: res = a;
    endcase
  end

endmodule

// ---- msq_core.v ----
// instruction sequencing core: cycle divider, fetch pipeline, decode, data memory, stack
// assumes a program memory on clk that presents prog_data for prog_addr within four clocks
`timescale 1ns/1ps
`include "msq_defines.vh"

module msq_core #(
  parameter DATA_W = 8,
  parameter PC_W = 11,
  parameter DADDR_W = 6,
  parameter STACK_DEPTH = 2
) (
  input wire clk,
  input wire rstn,
  input wire [13:0] prog_data,
  output reg [PC_W-1:0] prog_addr,
  output reg [DATA_W-1:0] acc,
  output reg flag_z,
  output reg flag_c,
  output reg flag_ac,
  output reg flag_ov,
  output reg cycle_end
);

  localparam ST_RUN = 2'h0;
  localparam ST_FLUSH = 2'h1;
  localparam ST_TABLE = 2'h2;
  localparam DMEM_DEPTH = 1 << DADDR_W;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [DATA_W-1:0] ram [0:DMEM_DEPTH-1];
  reg [STACK_DEPTH*PC_W-1:0] stack;
  reg [1:0] phase;
  reg [1:0] state;
  reg [13:0] ir;
  reg [DATA_W-1:0] tblp;
  reg [5:0] tblh;
  reg [PC_W-1:0] tab_ret;
  reg [DADDR_W-1:0] tab_dst;

  wire exec = (phase == `MSQ_PHASE_LAST);
  wire [2:0] cls = ir[`MSQ_CLS_HI:`MSQ_CLS_LO];
  wire dest_mem = ir[`MSQ_DEST_BIT];
  wire [5:0] func = ir[`MSQ_FUNC_HI:`MSQ_FUNC_LO];
  wire [DADDR_W-1:0] maddr = ir[`MSQ_ADDR_HI:`MSQ_ADDR_LO];
  wire [2:0] bidx = ir[`MSQ_BIDX_HI:`MSQ_BIDX_LO];
  wire [PC_W-1:0] cur_pc = prog_addr - {{(PC_W-1){1'b0}}, 1'b1};
  wire [PC_W-1:0] pc_inc = prog_addr + {{(PC_W-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------
  // operand read
  // ----------------------------------------------------------------
  reg [DATA_W-1:0] rd_val;
  always @* begin
    case (maddr)
      `MSQ_SFR_PCL: rd_val = cur_pc[DATA_W-1:0];
      `MSQ_SFR_TBLP: rd_val = tblp;
      `MSQ_SFR_TBLH: rd_val = {2'h0, tblh};
      `MSQ_SFR_STATUS: rd_val = {4'h0, flag_ov, flag_z, flag_ac, flag_c};
      default: rd_val = ram[maddr];
    endcase
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  reg [3:0] alu_op;
  reg [DATA_W-1:0] alu_b;
  reg use_bit;
  reg wr_acc, wr_mem, f_z, f_c, f_acov;
  reg skip, do_jump, do_push, do_pop, do_tab;
  reg [PC_W-1:0] jump_to;
  reg [DATA_W-1:0] bit_val;
  reg [DATA_W-1:0] wr_data;
  wire [DATA_W-1:0] alu_res;
  wire alu_c, alu_ac, alu_ov;

  msq_alu #(.DATA_W(DATA_W)) u_alu (
    .op(alu_op),
    .a(acc),
    .b(alu_b),
    .cin(flag_c),
    .res(alu_res),
    .cout(alu_c),
    .acout(alu_ac),
    .ovout(alu_ov)
  );

  always @* begin
    alu_op = `MSQ_ALU_PASSB;
    alu_b = rd_val;
    use_bit = 1'b0;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    f_z = 1'b0;
    f_c = 1'b0;
    f_acov = 1'b0;
    skip = 1'b0;
    do_jump = 1'b0;
    do_push = 1'b0;
    do_pop = 1'b0;
    do_tab = 1'b0;
    jump_to = ir[PC_W-1:0];
    bit_val = rd_val;
    if (state == ST_RUN) begin
      case (cls)
        `MSQ_CLS_JUMP: do_jump = 1'b1;
        `MSQ_CLS_CALL: begin
          do_jump = 1'b1;
          do_push = 1'b1;
        end
        `MSQ_CLS_BIT: begin
          // read-modify-write keeps the other seven bits as read
          case (ir[`MSQ_BSUB_HI:`MSQ_BSUB_LO])
            `MSQ_BSUB_SET: begin
              bit_val[bidx] = 1'b1;
              use_bit = 1'b1;
              wr_mem = 1'b1;
            end
            `MSQ_BSUB_CLR: begin
              bit_val[bidx] = 1'b0;
              use_bit = 1'b1;
              wr_mem = 1'b1;
            end
            `MSQ_BSUB_SKZ: skip = ~rd_val[bidx];
            default: skip = rd_val[bidx];
          endcase
        end
        `MSQ_CLS_IMM: begin
          alu_b = ir[`MSQ_IMM_HI:`MSQ_IMM_LO];
          wr_acc = 1'b1;
          case (ir[`MSQ_ISUB_HI:`MSQ_ISUB_LO])
            `MSQ_ISUB_ADD: alu_op = `MSQ_ALU_ADD;
            `MSQ_ISUB_SUB: alu_op = `MSQ_ALU_SUB;
            `MSQ_ISUB_AND: alu_op = `MSQ_ALU_AND;
            `MSQ_ISUB_OR: alu_op = `MSQ_ALU_OR;
            `MSQ_ISUB_XOR: alu_op = `MSQ_ALU_XOR;
            `MSQ_ISUB_MOV: alu_op = `MSQ_ALU_PASSB;
            default: wr_acc = 1'b0;
          endcase
        end
        default: begin
          if (func[5:4] == `MSQ_FGRP_ALU) begin
            alu_op = func[3:0];
            wr_acc = ~dest_mem;
            wr_mem = dest_mem;
          end else begin
            case (func)
              `MSQ_FUNC_SZ: begin
                wr_acc = ~dest_mem;
                skip = (rd_val == {DATA_W{1'b0}});
              end
              `MSQ_FUNC_SIZ, `MSQ_FUNC_SDZ: begin
                alu_op = (func == `MSQ_FUNC_SIZ) ? `MSQ_ALU_INC : `MSQ_ALU_DEC;
                wr_acc = ~dest_mem;
                wr_mem = dest_mem;
                skip = (alu_res == {DATA_W{1'b0}});
              end
              `MSQ_FUNC_TABRD: do_tab = 1'b1;
              `MSQ_FUNC_RET, `MSQ_FUNC_RETURN_FROM_INTERRUPT: begin
                do_jump = 1'b1;
                do_pop = 1'b1;
                jump_to = stack[PC_W-1:0];
              end
              default: skip = 1'b0;
            endcase
          end
        end
      endcase
      // flag groups per operation class
      if ((wr_acc || wr_mem) && !use_bit
          && (func[5:4] == `MSQ_FGRP_ALU || cls == `MSQ_CLS_IMM)) begin
        case (alu_op)
          `MSQ_ALU_ADD, `MSQ_ALU_ADC, `MSQ_ALU_SUB, `MSQ_ALU_SBC: begin
            f_z = 1'b1;
            f_c = 1'b1;
            f_acov = 1'b1;
          end
          `MSQ_ALU_AND, `MSQ_ALU_OR, `MSQ_ALU_XOR, `MSQ_ALU_CPL: f_z = 1'b1;
          `MSQ_ALU_INC, `MSQ_ALU_DEC: f_z = 1'b1;
          `MSQ_ALU_RRC, `MSQ_ALU_RLC: f_c = 1'b1;
          default: f_z = 1'b0;
        endcase
      end
    end
    wr_data = use_bit ? bit_val : alu_res;
    if (wr_mem && (maddr == `MSQ_SFR_PCL)) begin
      do_jump = 1'b1;
      jump_to = {cur_pc[PC_W-1:DATA_W], wr_data};
    end
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase <= `MSQ_PHASE_FIRST;
      cycle_end <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      cycle_end <= exec;
    end
  end

  // after reset the pipeline holds no valid word, so the first cycle only fetches
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_FLUSH;
      ir <= `MSQ_NOP_WORD;
      prog_addr <= {PC_W{1'b0}};
      tab_ret <= {PC_W{1'b0}};
      tab_dst <= {DADDR_W{1'b0}};
    end else if (exec) begin
      case (state)
        ST_RUN: begin
          if (do_tab) begin
            // keep the prefetched word in ir, borrow the fetch port for the table
            ir <= prog_data;
            tab_ret <= pc_inc;
            tab_dst <= maddr;
            prog_addr <= {cur_pc[PC_W-1:DATA_W], tblp};
            state <= ST_TABLE;
          end else begin
            ir <= prog_data;
            prog_addr <= do_jump ? jump_to : pc_inc;
            state <= (do_jump || skip) ? ST_FLUSH : ST_RUN;
          end
        end
        ST_TABLE: begin
          prog_addr <= tab_ret;
          state <= ST_RUN;
        end
        default: begin
          ir <= prog_data;
          prog_addr <= pc_inc;
          state <= ST_RUN;
        end
      endcase
    end
  end

  // two-deep stack; a third call drops the oldest entry
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stack <= {(STACK_DEPTH*PC_W){1'b0}};
    end else if (exec && do_push) begin
      stack <= {stack[(STACK_DEPTH-1)*PC_W-1:0], prog_addr};
    end else if (exec && do_pop) begin
      stack <= {{PC_W{1'b0}}, stack[STACK_DEPTH*PC_W-1:PC_W]};
    end
  end

  // ----------------------------------------------------------------
  // accumulator, flags and special registers
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc <= {DATA_W{1'b0}};
      flag_z <= 1'b0;
      flag_c <= 1'b0;
      flag_ac <= 1'b0;
      flag_ov <= 1'b0;
      tblp <= {DATA_W{1'b0}};
      tblh <= 6'h00;
    end else if (exec && state == ST_TABLE) begin
      tblh <= prog_data[13:8];
      if (tab_dst == `MSQ_SFR_TBLP) begin
        tblp <= prog_data[DATA_W-1:0];
      end
    end else if (exec && state == ST_RUN) begin
      if (wr_acc) begin
        acc <= wr_data;
      end
      if (wr_mem && maddr == `MSQ_SFR_TBLP) begin
        tblp <= wr_data;
      end
      if (wr_mem && maddr == `MSQ_SFR_STATUS) begin
        flag_c <= wr_data[`MSQ_STAT_C];
        flag_ac <= wr_data[`MSQ_STAT_AC];
        flag_z <= wr_data[`MSQ_STAT_Z];
        flag_ov <= wr_data[`MSQ_STAT_OV];
      end else begin
        if (f_z) begin
          flag_z <= (alu_res == {DATA_W{1'b0}});
        end
        if (f_c) begin
          flag_c <= alu_c;
        end
        if (f_acov) begin
          flag_ac <= alu_ac;
          flag_ov <= alu_ov;
        end
      end
    end
  end

  // general data memory; special addresses never land in the array
  always @(posedge clk) begin
    if (exec && state == ST_RUN && wr_mem && maddr != `MSQ_SFR_PCL && maddr != `MSQ_SFR_TBLP
        && maddr != `MSQ_SFR_TBLH && maddr != `MSQ_SFR_STATUS) begin
      ram[maddr] <= wr_data;
    end else if (exec && state == ST_TABLE && tab_dst != `MSQ_SFR_PCL
        && tab_dst != `MSQ_SFR_TBLP && tab_dst != `MSQ_SFR_TBLH
        && tab_dst != `MSQ_SFR_STATUS) begin
      ram[tab_dst] <= prog_data[DATA_W-1:0];
    end
  end

endmodule

// ---- msq_core_asserts.sv ----
// checker for the instruction sequencing core: cycle timing and fetch order
// assumes it is bound onto msq_core; a fetched word counts only at its exec edge
`timescale 1ns/1ps

module msq_core_asserts #(
  parameter DATA_W = 8,
  parameter PC_W = 11
) (
  input wire clk,
  input wire rstn,
  input wire [13:0] prog_data,
  input wire [PC_W-1:0] prog_addr,
  input wire [DATA_W-1:0] acc,
  input wire flag_z,
  input wire flag_c,
  input wire flag_ac,
  input wire flag_ov,
  input wire cycle_end
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // jump or call fetched in order, then taken on the following exec edge
  sequence s_taken;
    cycle_end && prog_addr == $past(prog_addr) + 1'b1 && $past(prog_data[13:12]) == 2'h3
      ##4 cycle_end && prog_addr == $past(prog_data[10:0], 5);
  endsequence

  property p_period;
    cycle_end |=> !cycle_end [*3] ##1 cycle_end;
  endproperty
  a_period: assert property (p_period)
    else $error("cycle_end not every four clocks");

  property p_first;
    $rose(rstn) |-> !cycle_end [*4] ##1 (cycle_end && prog_addr == 1);
  endproperty
  a_first: assert property (p_first)
    else $error("first instruction cycle mistimed");

  property p_addr_hold;
    $changed(prog_addr) |-> cycle_end;
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("fetch address moved inside an instruction cycle");

  property p_acc_hold;
    $changed(acc) |-> cycle_end;
  endproperty
  a_acc_hold: assert property (p_acc_hold)
    else $error("accumulator moved inside an instruction cycle");

  property p_flag_hold;
    $changed({flag_ov, flag_ac, flag_z, flag_c}) |-> cycle_end;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flags moved inside an instruction cycle");

  // the second choice covers a skip that discards the fetched word
  property p_target;
    cycle_end && prog_addr == $past(prog_addr) + 1'b1 && $past(prog_data[13:12]) == 2'h3
      |-> ##4 cycle_end && (prog_addr == $past(prog_data[10:0], 5)
      || prog_addr == $past(prog_addr, 5) + 2'h2);
  endproperty
  a_target: assert property (p_target)
    else $error("jump or call target not loaded");

  property p_refetch;
    s_taken |-> ##4 cycle_end && prog_addr == $past(prog_addr, 4) + 1'b1;
  endproperty
  a_refetch: assert property (p_refetch)
    else $error("no refetch from the new address");

  property p_flush_idle;
    s_taken |-> ##4 acc == $past(acc, 4) && flag_c == $past(flag_c, 4);
  endproperty
  a_flush_idle: assert property (p_flush_idle)
    else $error("extra cycle of a jump changed state");
endmodule

bind msq_core msq_core_asserts #(.DATA_W(DATA_W), .PC_W(PC_W)) u_msq_chk (.clk(clk),
  .rstn(rstn), .prog_data(prog_data), .prog_addr(prog_addr), .acc(acc), .flag_z(flag_z),
  .flag_c(flag_c), .flag_ac(flag_ac), .flag_ov(flag_ov), .cycle_end(cycle_end));

// ---- msq_core_tb.sv ----
// self-checking bench for the instruction sequencing core
// assumes the bench's program array answers the fetch address on every clock
`timescale 1ns/1ps
`include "msq_defines.vh"

module msq_core_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [13:0] prog_data = `MSQ_NOP_WORD;
  logic [13:0] rom [0:2047];
  wire [10:0] prog_addr;
  wire [7:0] acc;
  wire flag_z, flag_c, flag_ac, flag_ov, cycle_end;
  int err_count = 0;
  int check_count = 0;
  int n;
  logic poison;

  msq_core uut (.clk(clk), .rstn(rstn), .prog_data(prog_data), .prog_addr(prog_addr),
    .acc(acc), .flag_z(flag_z), .flag_c(flag_c), .flag_ac(flag_ac), .flag_ov(flag_ov),
    .cycle_end(cycle_end));

  initial forever #50 clk = ~clk;

  // the core samples only at exec edges, so answering every clock is harmless
  always @(posedge clk) prog_data <= rom[prog_addr];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [13:0] imm(input logic [2:0] s, input logic [7:0] x);
    return {`MSQ_CLS_IMM, s, x};
  endfunction
  function automatic logic [13:0] mop(input logic d, input logic [5:0] f, input logic [5:0] m);
    return {1'b0, d, f, m};
  endfunction
  function automatic logic [13:0] bop(input logic [1:0] s, input logic [2:0] i,
    input logic [5:0] m);
    return {`MSQ_CLS_BIT, s, i, m};
  endfunction
  function automatic logic [13:0] jump_to(input logic [2:0] c, input logic [10:0] a);
    return {c, a};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic load_reset();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
  endtask

  // counts instruction cycles until acc shows mark (9'h100: none) or stop cycles pass
  task automatic run_until(input logic [8:0] mark, input int stop, output int cnt);
    cnt = 0;
    poison = 1'b0;
    for (int k = 0; k < 400; k++) begin
      @(posedge clk);
      #1;
      if (acc === 8'hEE) poison = 1'b1;
      if (cycle_end === 1'b1) begin
        cnt++;
        if ({1'b0, acc} === mark || cnt == stop) return;
      end
    end
    err_count++;
    $display("BAD at %0t: wait ran out", $time);
    print_verdict();
  endtask

  task automatic clear_rom();
    foreach (rom[i]) rom[i] = `MSQ_NOP_WORD;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_jump();
    clear_rom();
    rom[0] = imm(`MSQ_ISUB_MOV, 8'h07);
    rom[1] = jump_to(`MSQ_CLS_JUMP, 11'h004);
    rom[2] = imm(`MSQ_ISUB_MOV, 8'hEE);
    rom[3] = imm(`MSQ_ISUB_MOV, 8'hEE);
    rom[4] = imm(`MSQ_ISUB_MOV, 8'h5A);
    load_reset();
    run_until(9'h007, 0, n);
    check(16'(n), 16'd2, "first cycles");
    run_until(9'h05A, 0, n);
    check(16'(n), 16'd3, "jump cycles");
    check({15'h0, poison}, 16'h0, "discarded word ran");
    $display("test jump done");
  endtask

  task automatic t_call();
    clear_rom();
    rom[0] = jump_to(`MSQ_CLS_CALL, 11'h004);
    rom[1] = imm(`MSQ_ISUB_MOV, 8'h33);
    rom[2] = jump_to(`MSQ_CLS_JUMP, 11'h002);
    rom[3] = imm(`MSQ_ISUB_MOV, 8'hEE);
    rom[4] = imm(`MSQ_ISUB_MOV, 8'h11);
    rom[5] = mop(1'b0, 6'h14, 6'h00);
    load_reset();
    run_until(9'h011, 0, n);
    check(16'(n), 16'd4, "call cycles");
    run_until(9'h033, 0, n);
    check(16'(n), 16'd3, "return cycles");
    check({15'h0, poison}, 16'h0, "wrong return");
    $display("test call done");
  endtask

  task automatic t_pc_low();
    clear_rom();
    rom[0] = imm(`MSQ_ISUB_MOV, 8'h03);
    rom[1] = mop(1'b1, 6'h0F, 6'h02); // write of the program counter low byte
    rom[2] = imm(`MSQ_ISUB_MOV, 8'hEE);
    rom[3] = imm(`MSQ_ISUB_MOV, 8'h44);
    load_reset();
    run_until(9'h003, 0, n);
    run_until(9'h044, 0, n);
    check(16'(n), 16'd3, "low byte write cycles");
    check({15'h0, poison}, 16'h0, "no jump");
    $display("test pc low done");
  endtask

  task automatic t_skip();
    clear_rom();
    rom[0] = imm(`MSQ_ISUB_MOV, 8'h00);
    rom[1] = mop(1'b1, 6'h0F, 6'h10);
    rom[2] = mop(1'b1, 6'h10, 6'h10);
    rom[3] = imm(`MSQ_ISUB_MOV, 8'hEE);
    rom[4] = imm(`MSQ_ISUB_MOV, 8'h66);
    rom[5] = mop(1'b1, 6'h11, 6'h10);
    rom[6] = imm(`MSQ_ISUB_MOV, 8'h77);
    load_reset();
    run_until(9'h066, 0, n);
    check(16'(n), 16'd6, "taken skip cycles");
    run_until(9'h077, 0, n);
    check(16'(n), 16'd2, "untaken skip cycles");
    check({15'h0, poison}, 16'h0, "skipped word ran");
    $display("test skip done");
  endtask

  task automatic t_bits();
    clear_rom();
    rom[0] = imm(`MSQ_ISUB_MOV, 8'hF0);
    rom[1] = mop(1'b1, 6'h0F, 6'h11);
    rom[2] = bop(`MSQ_BSUB_SET, 3'd0, 6'h11);
    rom[3] = bop(`MSQ_BSUB_CLR, 3'd7, 6'h11);
    rom[4] = bop(`MSQ_BSUB_SKZ, 3'd7, 6'h11);
    rom[5] = imm(`MSQ_ISUB_MOV, 8'hEE);
    rom[6] = bop(`MSQ_BSUB_SKZ, 3'd0, 6'h11);
    rom[7] = bop(`MSQ_BSUB_SKNZ, 3'd1, 6'h11);
    rom[8] = mop(1'b0, 6'h0E, 6'h11);
    rom[9] = bop(`MSQ_BSUB_SKNZ, 3'd4, 6'h11);
    rom[10] = imm(`MSQ_ISUB_MOV, 8'hEE);
    rom[11] = imm(`MSQ_ISUB_MOV, 8'h3C);
    load_reset();
    run_until(9'h071, 0, n);
    check(16'(n), 16'd10, "bit ops cycles");
    run_until(9'h03C, 0, n);
    check(16'(n), 16'd3, "bit skip cycles");
    check({15'h0, poison}, 16'h0, "bit skip wrong");
    $display("test bits done");
  endtask

  task automatic t_table();
    clear_rom();
    rom[0] = imm(`MSQ_ISUB_MOV, 8'h20);
    rom[1] = mop(1'b1, 6'h0F, `MSQ_SFR_TBLP);
    rom[2] = mop(1'b1, `MSQ_FUNC_TABRD, 6'h0D);
    rom[3] = mop(1'b0, 6'h0E, 6'h0D);
    rom[4] = mop(1'b0, 6'h0E, `MSQ_SFR_TBLH);
    rom[5] = jump_to(`MSQ_CLS_JUMP, 11'h005);
    rom[32] = 14'h02A5;
    load_reset();
    run_until(9'h0A5, 0, n);
    check(16'(n), 16'd6, "table read cycles");
    run_until(9'h100, 1, n);
    check({8'h00, acc}, 16'h0002, "table high bits");
    $display("test table done");
  endtask

  // fields: carry set first, dest memory, op, a, b, result, {ov, ac, z, c}
  function automatic logic [33:0] vec(input int i);
    case (i)
      0: return {2'b00, 32'h0F020101};
      1: return {2'b00, 32'h0808000B};
      2: return {2'b01, 32'h07F0180C};
      3: return {2'b00, 32'h21020F04};
      4: return {2'b00, 32'h22020007};
      5: return {2'b00, 32'h280017F9};
      6: return {2'b00, 32'h3100F003};
      7: return {2'b00, 32'h40FF0002};
      8: return {2'b01, 32'h50180810};
      9: return {2'b00, 32'h65A5A002};
      10: return {2'b00, 32'h700FF002};
      11: return {2'b01, 32'h7000FF00};
      12: return {2'b00, 32'h800FF002};
      13: return {2'b01, 32'h90000FF0};
      14: return {2'b00, 32'hA0001800};
      15: return {2'b01, 32'hB0081030};
      16: return {2'b00, 32'hC0001001};
      17: return {2'b10, 32'hC0002816};
      18: return {2'b11, 32'hD0040816};
      19: return {2'b10, 32'h10101030};
      20: return {2'b10, 32'h3100F011};
      default: return {2'b00, 32'hE003C3C0};
    endcase
  endfunction

  task automatic t_alu();
    logic [33:0] v;
    for (int i = 0; i < 22; i++) begin
      v = vec(i);
      clear_rom();
      rom[0] = imm(`MSQ_ISUB_MOV, v[19:12]);
      rom[1] = mop(1'b1, 6'h0F, 6'h0C);
      rom[2] = imm(`MSQ_ISUB_MOV, 8'hFF);
      if (v[33]) rom[3] = imm(`MSQ_ISUB_ADD, 8'h01);
      rom[4] = imm(`MSQ_ISUB_MOV, v[27:20]);
      rom[5] = mop(v[32], {2'b00, v[31:28]}, 6'h0C);
      if (v[32]) rom[6] = mop(1'b0, 6'h0E, 6'h0C);
      rom[7] = jump_to(`MSQ_CLS_JUMP, 11'h007);
      load_reset();
      run_until(9'h100, 8, n);
      check({8'h00, acc}, {8'h00, v[11:4]}, "alu result");
      check({12'h0, flag_ov, flag_ac, flag_z, flag_c}, {12'h0, v[3:0]}, "flags");
    end
    $display("test alu done");
  endtask

  initial begin
    t_jump();
    t_call();
    t_pc_low();
    t_skip();
    t_bits();
    t_table();
    t_alu();
    print_verdict();
  end
endmodule
